// ==== hdl/gptm_regs.svh ====
`ifndef GPTM_REGS_SVH
`define GPTM_REGS_SVH
// Register indices as printed, byte address is four times the index
`define GPTM_IDX_CTRL 8'h11
`define GPTM_IDX_TO_HI 8'h12
`define GPTM_IDX_TO_LO 8'h13
`define GPTM_IDX_MASK 8'h14
`define GPTM_IDX_STAT 8'h17
`define GPTM_IDX_CMD 8'h20
`define GPTM_IDX_LIVE 8'h21
`define GPTM_IDX_SRC 8'h22
`define GPTM_IDX_SMSK 8'h23
// Field positions in the control register
`define GPTM_TRIG_MSB 7
`define GPTM_TRIG_LSB 5
`define GPTM_EMV_BIT 1
`define GPTM_STEP_BIT 0
// Command register bits
`define GPTM_CMD_START 0
`define GPTM_CMD_DEFAULT 1
// Reset values
`define GPTM_CTRL_RST 8'h00
`define GPTM_MASK_RST 8'h00
`define GPTM_TO_RST 16'h0000
// Carrier periods per timeout unit, and carrier divider step
`define GPTM_UNIT_FC 8
`define GPTM_NRT_STEP_SHORT 64
`define GPTM_NRT_STEP_LONG 4096
`endif

// ==== hdl/gptm_pkg.sv ====
package gptm_pkg;
  // Trigger source codes
  typedef enum logic [2:0] {
    GPTM_TRIG_CMD = 3'h0,
    GPTM_TRIG_RX_END = 3'h1,
    GPTM_TRIG_RX_START = 3'h2,
    GPTM_TRIG_TX_END_NFC = 3'h3
  } gptm_trig_t;
  // Events seen by the block, one cycle pulses
  typedef struct packed {
    logic osc_stable;
    logic water_level;
    logic rx_start;
    logic rx_end;
    logic tx_end;
    logic collision;
    logic timer_nfc;
    logic err_wake;
  } gptm_evt_t;
endpackage : gptm_pkg

// ==== hdl/gptm_counter.sv ====
`timescale 1ns/1ps
// Down counter of the general purpose timer, counting on a unit enable
module gptm_counter #(
  parameter int WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic unit_tick,
  input wire logic start,
  input wire logic [WIDTH-1:0] load_value,
  output logic running,
  output logic expired
);
  logic [WIDTH-1:0] count; // Units still to go
  initial begin
    if (WIDTH < 2) $error("gptm_counter WIDTH too small");
  end
  // Load on start, count down per unit, pulse on reaching zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count <= load_value;
        running <= 1'b1;
      end else if (running && unit_tick) begin
        if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule : gptm_counter

// ==== hdl/gptm_top.sv ====
//Operation
// R1: Control bits 7..5 select timer trigger
// R2: Code zero starts only by command
// R3: Code one rx end, two rx start
// R4: Code three tx end; expiry drops field
// R5: Codes four to seven never start timer; the command start still starts it
// R6: Control bit 1 selects EMV mode
// R7: Control bit 0 selects 64 or 4096 step
// R8: Timeout high byte 12h, low 13h
// R9: Timeout counted in eight carrier periods
// R10: Defaults on reset and set-default command
// R11: Mask bit 7 blocks oscillator stable irq
// R12: Mask bits 6..2 block their events
// R13: Control and mask reset zero, unused zero
// R14: Status read clears, except summary bits
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "gptm_regs.svh"
module gptm_top import gptm_pkg::*; #(
  parameter int FC_DIV = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fc_tick,
  input wire gptm_evt_t events,
  input wire logic nfc_mode,
  input wire logic timer_detail_read,
  input wire logic err_detail_read,
  output logic gp_expired,
  output logic gp_running,
  output logic field_off,
  output logic nrt_emv_mode,
  output logic nrt_step_long,
  output logic irq,
  output logic src_irq
);
  initial begin
    if (FC_DIV < 1) $error("gptm_top FC_DIV must be at least one");
  end
  // Byte address of an index
  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    addr_of = {2'b00, idx, 2'b00};
  endfunction : addr_of
  // Registers
  logic [7:0] ctrl; // Trigger and step control
  logic [7:0] to_hi; // Timeout high byte
  logic [7:0] to_lo; // Timeout low byte
  logic [7:0] mask; // Main interrupt mask
  logic [7:0] stat; // Main interrupt status
  logic [1:0] src; // Block sticky events: bit0 expiry, bit1 field off
  logic [1:0] smsk; // Mask for the block events
  // Write channel capture
  logic aw_hold;
  logic w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire do_write = aw_hold && w_hold && !s_axi_bvalid;
  wire wr_byte = do_write && w_strb[0];
  wire wr_ctrl = wr_byte && aw_addr == addr_of(`GPTM_IDX_CTRL);
  wire wr_hi = wr_byte && aw_addr == addr_of(`GPTM_IDX_TO_HI);
  wire wr_lo = wr_byte && aw_addr == addr_of(`GPTM_IDX_TO_LO);
  wire wr_mask = wr_byte && aw_addr == addr_of(`GPTM_IDX_MASK);
  wire wr_cmd = wr_byte && aw_addr == addr_of(`GPTM_IDX_CMD);
  wire wr_src = wr_byte && aw_addr == addr_of(`GPTM_IDX_SRC);
  wire wr_smsk = wr_byte && aw_addr == addr_of(`GPTM_IDX_SMSK);
  wire wr_known = wr_ctrl | wr_hi | wr_lo | wr_mask | wr_cmd | wr_src | wr_smsk
    | (do_write && !w_strb[0] && aw_addr[11:10] == 2'b00);
  wire cmd_start = wr_cmd && w_data[`GPTM_CMD_START];
  wire cmd_default = wr_cmd && w_data[`GPTM_CMD_DEFAULT];
  // Read decode
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_stat = rd_take && s_axi_araddr == addr_of(`GPTM_IDX_STAT);
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      addr_of(`GPTM_IDX_CTRL): rd_word = {24'h000000, ctrl};
      addr_of(`GPTM_IDX_TO_HI): rd_word = {24'h000000, to_hi};
      addr_of(`GPTM_IDX_TO_LO): rd_word = {24'h000000, to_lo};
      addr_of(`GPTM_IDX_MASK): rd_word = {24'h000000, mask};
      addr_of(`GPTM_IDX_STAT): rd_word = {24'h000000, stat};
      addr_of(`GPTM_IDX_CMD): rd_word = 32'h00000000;
      addr_of(`GPTM_IDX_LIVE): rd_word = {30'h00000000, gp_running, field_off};
      addr_of(`GPTM_IDX_SRC): rd_word = {30'h00000000, src};
      addr_of(`GPTM_IDX_SMSK): rd_word = {30'h00000000, smsk};
      default: begin
        rd_word = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end
  // Write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {s_axi_araddr[1:0] == 2'b00 ? rd_word : 32'h00000000};
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  // Timeout default as a whole word, so each byte is a plain part-select
  localparam logic [15:0] TO_RST = `GPTM_TO_RST;
  // Configuration registers
  always_ff @(posedge aclk) begin
    // R10: defaults on reset
    if (!aresetn || cmd_default) begin
      // R13: zero reset
      ctrl <= `GPTM_CTRL_RST;
      mask <= `GPTM_MASK_RST;
      to_hi <= TO_RST[15:8];
      to_lo <= TO_RST[7:0];
      smsk <= 2'b00;
    end else begin
      // R13: unused bits zero
      if (wr_ctrl) ctrl <= w_data[7:0] & 8'he3;
      // R8: high timeout byte
      if (wr_hi) to_hi <= w_data[7:0];
      // R8: low timeout byte
      if (wr_lo) to_lo <= w_data[7:0];
      // R13: unused mask bits zero
      if (wr_mask) mask <= w_data[7:0] & 8'hfc;
      if (wr_smsk) smsk <= w_data[1:0];
    end
  end
  // R6: EMV mode select
  wire next_emv = ctrl[`GPTM_EMV_BIT];
  // R7: step select
  wire next_step = ctrl[`GPTM_STEP_BIT];
  // R1: trigger field
  wire [2:0] trig = ctrl[`GPTM_TRIG_MSB:`GPTM_TRIG_LSB];
  // R2: command start always allowed, R3 and R4 event starts
  // R5: codes four to seven match nothing
  wire auto_start = (trig == GPTM_TRIG_RX_END && events.rx_end)
    || (trig == GPTM_TRIG_RX_START && events.rx_start)
    || (trig == GPTM_TRIG_TX_END_NFC && events.tx_end && nfc_mode);
  wire gp_start = cmd_start || auto_start;
  // Latch whether a code three event, not a command, started the timer so a later change does not alter the expiry action
  logic armed_nfc;
  // Divider of the carrier tick into eight carrier period units
  logic [2:0] fc_cnt;
  wire unit_tick = fc_tick && fc_cnt == 3'h7;
  // R9: eight carrier periods per unit
  always_ff @(posedge aclk) begin
    if (!aresetn || gp_start) fc_cnt <= 3'h0;
    else if (fc_tick) fc_cnt <= fc_cnt + 3'h1;
  end
  logic cnt_running;
  logic cnt_expired;
  gptm_counter #(.WIDTH(16)) u_counter (
    .aclk(aclk),
    .aresetn(aresetn && !cmd_default),
    .unit_tick(unit_tick),
    .start(gp_start),
    .load_value({to_hi, to_lo}),
    .running(cnt_running),
    .expired(cnt_expired)
  );
  // Timer outputs and field control
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_default) begin
      armed_nfc <= 1'b0;
      field_off <= 1'b0;
      gp_expired <= 1'b0;
      gp_running <= 1'b0;
      nrt_emv_mode <= 1'b0;
      nrt_step_long <= 1'b0;
    end else begin
      if (gp_start) armed_nfc <= !cmd_start && trig == GPTM_TRIG_TX_END_NFC;
      // R4: field off at expiry
      if (cnt_expired && armed_nfc) field_off <= 1'b1;
      else if (cmd_start) field_off <= 1'b0;
      gp_expired <= cnt_expired;
      gp_running <= cnt_running;
      nrt_emv_mode <= next_emv;
      nrt_step_long <= next_step;
    end
  end
  // Main interrupt status: event sets win over read clear
  wire [7:0] evt_bits = events;
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_default) begin
      stat <= 8'h00;
    end else begin
      // R14: read clears all but summary bits
      stat[7:2] <= (rd_stat ? 6'h00 : stat[7:2]) | evt_bits[7:2];
      stat[1] <= (timer_detail_read ? 1'b0 : stat[1]) | evt_bits[1];
      stat[0] <= (err_detail_read ? 1'b0 : stat[0]) | evt_bits[0];
    end
  end
  // Block events, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_default) src <= 2'b00;
    else src <= (src & ~(wr_src ? w_data[1:0] : 2'b00)) | {cnt_expired && armed_nfc, cnt_expired};
  end
  // R11: mask bit 7 blocks, R12: bits 6..2
  wire irq_main = |(stat & ~mask);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      src_irq <= 1'b0;
    end else begin
      irq <= irq_main;
      src_irq <= |(src & ~smsk);
    end
  end
endmodule : gptm_top

// ==== dv/gptm_assertions.sv ====
`timescale 1ns/1ps
// Port-level checks on the timer block
module gptm_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic gp_expired,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error data not zero");
  reset_quiet_a: assert property ($rose(aresetn) |-> !irq && !gp_expired && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  expiry_pulse_a: assert property (gp_expired |=> !gp_expired) else $error("expiry not a pulse");
endmodule : gptm_chk
bind gptm_top gptm_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .gp_expired, .irq);

// ==== dv/gptm_fe_model.sv ====
`timescale 1ns/1ps
// Front end model: carrier tick every second cycle, event pulses on request
module gptm_fe_model import gptm_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire gptm_evt_t req,
  output logic fc_tick,
  output gptm_evt_t events
);
  // Events copy the request one cycle later, zero in reset
  always_ff @(posedge aclk) begin
    fc_tick <= aresetn & ~fc_tick;
    events <= aresetn ? req : '0;
  end
endmodule : gptm_fe_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import gptm_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, nfc_mode = 1, timer_detail_read = 0, err_detail_read = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fc_tick;
  logic gp_expired, gp_running, field_off, nrt_emv_mode, nrt_step_long, irq, src_irq;
  gptm_evt_t events, req = '0;
  int num_errors = 0, checks_done = 0, n, c, k;
  logic [7:0] et [3] = '{8'h10, 8'h20, 8'h08};
  always #4 aclk = ~aclk;
  gptm_top #(.FC_DIV(1)) uut (.*);
  gptm_fe_model u_fe (.aclk, .aresetn, .req, .fc_tick, .events);
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic hang(input int i);
    if (i >= 199) begin
      num_errors++;
      $display("FAIL %0t timeout", $time);
      close_out();
    end
  endtask : hang
  task automatic cyc(input int i);
    repeat (i) @(posedge aclk);
  endtask : cyc
  // Write one register, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 199; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    hang(n);
  endtask : wr
  // Read one register and compare data and response
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 199; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    hang(n);
    chk(s_axi_rdata, {24'h0, e});
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : rd
  task automatic ev(input logic [7:0] e);
    @(posedge aclk);
    req <= gptm_evt_t'(e);
    @(posedge aclk);
    req <= '0;
    cyc(3);
  endtask : ev
  task automatic idle;
    for (n = 0; n < 199 && gp_running !== 0; n++) @(posedge aclk);
    hang(n);
  endtask : idle
  initial begin
    cyc(10);
    aresetn <= 1;
    rd(12'h044, 8'h00);
    rd(12'h050, 8'h00);
    wr(12'h044, 8'hff);
    rd(12'h044, 8'he3);
    chk({nrt_emv_mode, nrt_step_long}, 2'h3);
    wr(12'h044, 8'h01);
    cyc(2);
    chk({nrt_emv_mode, nrt_step_long}, 2'h1);
    wr(12'h048, 8'hab);
    wr(12'h04c, 8'hcd);
    rd(12'h048, 8'hab);
    rd(12'h04c, 8'hcd);
    $display("registers done");
    wr(12'h048, 8'h00);
    wr(12'h04c, 8'h01);
    // Every trigger code against the rx end, rx start and tx end events
    for (c = 0; c < 8; c++) begin
      wr(12'h044, {c[2:0], 5'h0});
      for (k = 0; k < 3; k++) begin
        ev(et[k]);
        chk(gp_running, c == k + 1);
        idle();
      end
    end
    chk(field_off, 1);
    // Code three outside NFC mode must not start the timer
    nfc_mode <= 1'b0;
    wr(12'h044, 8'h60);
    ev(8'h08);
    chk(gp_running, 0);
    nfc_mode <= 1'b1;
    rd(12'h084, 8'h01);
    chk(src_irq, 1);
    wr(12'h08c, 8'h03);
    cyc(2);
    chk(src_irq, 0);
    wr(12'h088, 8'h03);
    wr(12'h08c, 8'h00);
    rd(12'h088, 8'h00);
    chk(src_irq, 0);
    $display("triggers done");
    // Command start, three units of eight ticks
    wr(12'h044, 8'h00);
    wr(12'h04c, 8'h03);
    wr(12'h080, 8'h01);
    for (n = 0; n < 99 && gp_expired !== 1; n++) @(posedge aclk);
    chk(n >= 44 && n <= 54, 1);
    chk(field_off, 0);
    idle();
    // Receive start, receive end and transmit end were raised by the trigger sweep
    rd(12'h05c, 8'h38);
    @(posedge aclk);
    {timer_detail_read, err_detail_read} <= 2'h3;
    @(posedge aclk);
    {timer_detail_read, err_detail_read} <= 2'h0;
    rd(12'h05c, 8'h00);
    // Each main source raised, read clear, masked
    for (k = 2; k < 8; k++) begin
      ev(8'h01 << k);
      chk(irq, 1);
      rd(12'h05c, 8'h01 << k);
      cyc(2);
      chk(irq, 0);
      wr(12'h050, 8'h01 << k);
      ev(8'h01 << k);
      chk(irq, 0);
      rd(12'h05c, 8'h01 << k);
      wr(12'h050, 8'h00);
    end
    // Summary bits survive status reads
    for (k = 0; k < 2; k++) begin
      ev(8'h01 << k);
      rd(12'h05c, 8'h01 << k);
      rd(12'h05c, 8'h01 << k);
      @(posedge aclk);
      {timer_detail_read, err_detail_read} <= 2'h1 << k;
      @(posedge aclk);
      {timer_detail_read, err_detail_read} <= 2'h0;
      rd(12'h05c, 8'h00);
    end
    $display("interrupts done");
    wr(12'h044, 8'he3);
    wr(12'h050, 8'hfc);
    wr(12'h048, 8'h55);
    wr(12'h080, 8'h02);
    rd(12'h044, 8'h00);
    rd(12'h050, 8'h00);
    rd(12'h048, 8'h00);
    rd(12'h000, 8'h00, 2'h2);
    $display("defaults done");
    close_out();
  end
endmodule : tb_top
